// file: hw/fcls_pkg.sv
/*
  constants, register map and state codes of the fiber-cut laser shutdown controller.
  assumes a 100 MHz system clock and an AXI4-Lite master with 32-bit data.
*/
// Notes on behaviour
// RQ1: continuity loss only while both losses present
// RQ2: loss commands booster off within three seconds
// RQ3: one continuity alarm, demote overhead and payload
// RQ4: service-channel laser off after booster shutdown
// RQ5: preamplifier shuts off on its own input loss
// RQ6: report service framing loss alongside overhead loss
// RQ7: passive node blocks switch and drops laser
// RQ8: same shutdown on own receive side
// RQ9: transmitters stay off until restart by mode
// RQ10: restart pulse answered; originator resumes on return
// RQ11: passive restart re-enables laser and passes switch
// RQ12: power reduced while any restart pulse emits
// RQ13: two-second service pulse, retry after 100 seconds
// RQ14: nine-second reduced pulse, answer within 100 seconds
// RQ15: mode disabled, auto, manual, test; auto default
// RQ16: second counters from prescaled tick, cleared at reset
package fcls_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SEC_NS        = 1000000000;
  localparam int unsigned TICK_CYCLES   = SEC_NS / CLK_PERIOD_NS;

  localparam logic [6:0] AMP_OFF_S   = 7'd3;
  localparam logic [6:0] SVC_PULSE_S = 7'd2;
  localparam logic [6:0] SVC_WAIT_S  = 7'd100;
  localparam logic [6:0] AMP_PULSE_S = 7'd9;
  localparam logic [6:0] AMP_WAIT_S  = 7'd100;

  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hC;

  localparam int unsigned CTRL_MODE_LSB   = 0;
  localparam int unsigned CTRL_PASSIVE    = 2;
  localparam int unsigned CTRL_RESTART    = 8;
  localparam int unsigned STAT_STATE_LSB  = 5;

  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_CONT_LOSS = 0;
  localparam int unsigned IRQ_SHUTDOWN  = 1;
  localparam int unsigned IRQ_RESTORED  = 2;
  localparam int unsigned IRQ_RETRY     = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_DISABLED = 2'h0,
    MODE_AUTO     = 2'h1,
    MODE_MANUAL   = 2'h2,
    MODE_TEST     = 2'h3
  } fcls_mode_e;

  localparam fcls_mode_e MODE_RST    = MODE_AUTO;
  localparam logic       PASSIVE_RST = 1'b0;
  localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

  typedef enum logic [5:0] {
    ST_RUN       = 6'b000001,
    ST_SHUT      = 6'b000010,
    ST_SVC_PULSE = 6'b000100,
    ST_SVC_WAIT  = 6'b001000,
    ST_AMP_PULSE = 6'b010000,
    ST_AMP_WAIT  = 6'b100000
  } fcls_state_e;
endpackage

// file: hw/fcls_tick.sv
/*
  prescaler that turns the system clock into a one-cycle pulse per second.
  assumes a synchronous active-high reset on the same clock.
*/
`timescale 1ns/1ns
module fcls_tick #(
  parameter int unsigned P_CYCLES = 100
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  output logic      o_tick
);
  logic [31:0] cnt_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_ff <= 32'h0;
      o_tick <= 1'b0;
    end else if (cnt_ff == P_CYCLES - 32'd1) begin // RQ16
      cnt_ff <= 32'h0;
      o_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 32'd1;
      o_tick <= 1'b0;
    end
  end
endmodule

// file: hw/fcls_top.sv
/*
  fiber-cut laser shutdown controller with AXI4-Lite registers and one interrupt.
  assumes loss and pulse-detect pins are asynchronous; one 100 MHz clock.
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module fcls_top #(
  parameter int unsigned P_TICK_CYCLES = fcls_pkg::TICK_CYCLES
) (
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_OVERHEAD_LOSS,
  input  wire logic        I_PAYLOAD_LOSS,
  input  wire logic        I_PRE_INPUT_LOSS,
  input  wire logic        I_SVC_FRAME_LOSS,
  input  wire logic        I_PEER_PULSE,
  output logic             O_BOOSTER_EN,
  output logic             O_BOOSTER_REDUCED,
  output logic             O_PREAMP_EN,
  output logic             O_SVC_LASER_EN,
  output logic             O_SVC_LOW_POWER,
  output logic             O_SWITCH_PASS,
  output logic             O_CONT_LOSS_ALARM,
  output logic             O_OVERHEAD_ALARM,
  output logic             O_PAYLOAD_ALARM,
  output logic             O_SVC_LOSS_IND,
  output logic             O_IRQ,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP
);
  localparam int unsigned NPIN = 5;

  logic [NPIN-1:0]      pin_raw;
  logic [NPIN-1:0]      sync_a_ff;
  logic [NPIN-1:0]      sync_b_ff;
  logic                 ovh_loss;
  logic                 pay_loss;
  logic                 pre_loss;
  logic                 svc_loss;
  logic                 peer_pulse;
  logic                 cont_loss;
  logic                 cont_loss_d_ff;
  logic                 tick;
  logic                 tick_rst;
  fcls_pkg::fcls_mode_e mode_ff;
  logic                 passive_ff;
  logic                 restart_req;
  fcls_pkg::fcls_state_e state_ff;
  fcls_pkg::fcls_state_e nxt_state;
  logic [6:0]           sec_ff;
  logic                 retry;
  logic [fcls_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [fcls_pkg::IRQ_W-1:0] irq_mask_ff;
  logic [fcls_pkg::IRQ_W-1:0] irq_set;
  logic                 aw_got_ff;
  logic                 w_got_ff;
  logic [3:0]           aw_addr_ff;
  logic [31:0]          w_data_ff;
  logic [3:0]           w_strb_ff;
  logic                 wr_do;
  logic                 rd_do;
  logic                 rd_clr;

  // address decode shared by both channels
  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == fcls_pkg::OFS_CTRL) || (a == fcls_pkg::OFS_STATUS) ||
              (a == fcls_pkg::OFS_IRQ_STAT) || (a == fcls_pkg::OFS_IRQ_MASK);
  endfunction

  assign pin_raw = {I_PEER_PULSE, I_SVC_FRAME_LOSS, I_PRE_INPUT_LOSS,
                    I_PAYLOAD_LOSS, I_OVERHEAD_LOSS};

  // pins are asynchronous to I_CLK; second stage is the only reader of the first
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
        sync_a_ff[g] <= 1'b0;
        sync_b_ff[g] <= 1'b0;
      end else begin
        sync_a_ff[g] <= pin_raw[g];
        sync_b_ff[g] <= sync_a_ff[g];
      end
    end
  end

  assign ovh_loss   = sync_b_ff[0];
  assign pay_loss   = sync_b_ff[1];
  assign pre_loss   = sync_b_ff[2];
  assign svc_loss   = sync_b_ff[3];
  assign peer_pulse = sync_b_ff[4];
  assign cont_loss  = ovh_loss & pay_loss; // RQ1 RQ8

  // prescaler restarts on every state change, so each timed interval is whole seconds long
  assign tick_rst = I_SYS_RST || (nxt_state != state_ff); // RQ13 RQ14 RQ16

  fcls_tick #(
    .P_CYCLES (P_TICK_CYCLES)
  ) u_tick (
    .i_clk  (I_CLK),
    .i_rst  (tick_rst),
    .o_tick (tick)
  );

  // seconds spent in the current state; saturates, so a stalled state stays safe
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || nxt_state != state_ff) begin
      sec_ff <= 7'h0; // RQ16
    end else if (tick && sec_ff != 7'h7F) begin
      sec_ff <= sec_ff + 7'h1; // RQ16
    end
  end

  always_comb begin
    nxt_state = state_ff;
    retry     = 1'b0;
    unique case (state_ff)
      fcls_pkg::ST_RUN: begin
        if (cont_loss && mode_ff != fcls_pkg::MODE_DISABLED) begin
          nxt_state = fcls_pkg::ST_SHUT; // RQ2 RQ4 RQ7
        end
      end
      fcls_pkg::ST_SHUT: begin
        if (mode_ff == fcls_pkg::MODE_DISABLED) begin
          nxt_state = fcls_pkg::ST_RUN;
        end else if (peer_pulse) begin
          nxt_state = fcls_pkg::ST_SVC_PULSE; // RQ10
        end else if (mode_ff == fcls_pkg::MODE_AUTO || restart_req) begin
          nxt_state = fcls_pkg::ST_SVC_PULSE; // RQ9
        end
      end
      fcls_pkg::ST_SVC_PULSE: begin
        if (sec_ff >= fcls_pkg::SVC_PULSE_S) begin
          nxt_state = fcls_pkg::ST_SVC_WAIT; // RQ13
        end
      end
      fcls_pkg::ST_SVC_WAIT: begin
        if (peer_pulse) begin
          nxt_state = passive_ff ? fcls_pkg::ST_RUN : fcls_pkg::ST_AMP_PULSE; // RQ11 RQ14
        end else if (sec_ff >= fcls_pkg::SVC_WAIT_S) begin
          retry     = 1'b1;
          nxt_state = (mode_ff == fcls_pkg::MODE_AUTO) ? fcls_pkg::ST_SVC_PULSE
                                                       : fcls_pkg::ST_SHUT; // RQ13
        end
      end
      fcls_pkg::ST_AMP_PULSE: begin
        if (sec_ff >= fcls_pkg::AMP_PULSE_S) begin
          nxt_state = fcls_pkg::ST_AMP_WAIT; // RQ14
        end
      end
      fcls_pkg::ST_AMP_WAIT: begin
        if (!pay_loss) begin
          nxt_state = fcls_pkg::ST_RUN; // RQ10 RQ14
        end else if (sec_ff >= fcls_pkg::AMP_WAIT_S) begin
          retry     = 1'b1;
          nxt_state = fcls_pkg::ST_SHUT;
        end
      end
      default: nxt_state = fcls_pkg::ST_SHUT;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state_ff <= fcls_pkg::ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // transmitter outputs registered from the next state so they align with state_ff
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_BOOSTER_EN      <= 1'b0;
      O_BOOSTER_REDUCED <= 1'b0;
      O_SVC_LASER_EN    <= 1'b0;
      O_SVC_LOW_POWER   <= 1'b0;
      O_SWITCH_PASS     <= 1'b0;
    end else begin
      O_BOOSTER_EN   <= !passive_ff && (nxt_state == fcls_pkg::ST_RUN ||
                        nxt_state == fcls_pkg::ST_AMP_PULSE); // RQ2 RQ9
      O_BOOSTER_REDUCED <= nxt_state == fcls_pkg::ST_AMP_PULSE; // RQ12
      O_SVC_LASER_EN <= nxt_state != fcls_pkg::ST_SHUT &&
                        nxt_state != fcls_pkg::ST_SVC_WAIT; // RQ4 RQ7 RQ9
      O_SVC_LOW_POWER <= nxt_state == fcls_pkg::ST_SVC_PULSE; // RQ12
      O_SWITCH_PASS  <= !passive_ff || nxt_state == fcls_pkg::ST_RUN; // RQ7 RQ11
    end
  end

  // preamp and alarms follow the synchronised inputs; one alarm replaces two
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_PREAMP_EN       <= 1'b0;
      O_CONT_LOSS_ALARM <= 1'b0;
      O_OVERHEAD_ALARM  <= 1'b0;
      O_PAYLOAD_ALARM   <= 1'b0;
      O_SVC_LOSS_IND    <= 1'b0;
      cont_loss_d_ff    <= 1'b0;
    end else begin
      O_PREAMP_EN       <= !pre_loss; // RQ5
      O_CONT_LOSS_ALARM <= cont_loss; // RQ3
      O_OVERHEAD_ALARM  <= ovh_loss && !pay_loss; // RQ3
      O_PAYLOAD_ALARM   <= pay_loss && !ovh_loss; // RQ3
      O_SVC_LOSS_IND    <= svc_loss; // RQ6
      cont_loss_d_ff    <= cont_loss;
    end
  end

  // write channel: address and data taken in either order, then one response
  assign S_AXI_AWREADY = !aw_got_ff && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_got_ff && !S_AXI_BVALID;
  assign wr_do         = aw_got_ff && w_got_ff && !S_AXI_BVALID;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_data_ff  <= 32'h0;
      w_strb_ff  <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= fcls_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= S_AXI_WDATA;
        w_strb_ff <= S_AXI_WSTRB;
      end
      if (wr_do) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= addr_ok(aw_addr_ff) ? fcls_pkg::RESP_OKAY
                                            : fcls_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  assign restart_req = wr_do && aw_addr_ff == fcls_pkg::OFS_CTRL && w_strb_ff[1] &&
                       w_data_ff[fcls_pkg::CTRL_RESTART] &&
                       mode_ff != fcls_pkg::MODE_DISABLED &&
                       mode_ff != fcls_pkg::MODE_AUTO;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      mode_ff     <= fcls_pkg::MODE_RST; // RQ15
      passive_ff  <= fcls_pkg::PASSIVE_RST;
      irq_mask_ff <= fcls_pkg::MASK_RST;
    end else if (wr_do && w_strb_ff[0]) begin
      if (aw_addr_ff == fcls_pkg::OFS_CTRL) begin
        mode_ff    <= fcls_pkg::fcls_mode_e'(w_data_ff[fcls_pkg::CTRL_MODE_LSB +: 2]);
        passive_ff <= w_data_ff[fcls_pkg::CTRL_PASSIVE];
      end
      if (aw_addr_ff == fcls_pkg::OFS_IRQ_MASK) begin
        irq_mask_ff <= w_data_ff[fcls_pkg::IRQ_W-1:0];
      end
    end
  end

  // read channel: one outstanding read, data registered
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_do         = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_clr        = rd_do && S_AXI_ARADDR == fcls_pkg::OFS_IRQ_STAT;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= fcls_pkg::RESP_OKAY;
    end else if (rd_do) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= addr_ok(S_AXI_ARADDR) ? fcls_pkg::RESP_OKAY
                                            : fcls_pkg::RESP_SLVERR;
      unique case (S_AXI_ARADDR)
        fcls_pkg::OFS_CTRL:
          S_AXI_RDATA <= {29'h0, passive_ff, mode_ff};
        fcls_pkg::OFS_STATUS:
          S_AXI_RDATA <= {21'h0, state_ff, svc_loss, pre_loss, pay_loss,
                          ovh_loss, cont_loss};
        fcls_pkg::OFS_IRQ_STAT:
          S_AXI_RDATA <= {28'h0, irq_stat_ff};
        fcls_pkg::OFS_IRQ_MASK:
          S_AXI_RDATA <= {28'h0, irq_mask_ff};
        default:
          S_AXI_RDATA <= 32'h0;
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // sticky events; a new event in the clearing read's cycle survives
  assign irq_set[fcls_pkg::IRQ_CONT_LOSS] = cont_loss && !cont_loss_d_ff;
  assign irq_set[fcls_pkg::IRQ_SHUTDOWN]  = nxt_state == fcls_pkg::ST_SHUT &&
                                            state_ff == fcls_pkg::ST_RUN;
  assign irq_set[fcls_pkg::IRQ_RESTORED]  = nxt_state == fcls_pkg::ST_RUN &&
                                            state_ff != fcls_pkg::ST_RUN;
  assign irq_set[fcls_pkg::IRQ_RETRY]     = retry;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      irq_stat_ff <= 4'h0;
    end else begin
      irq_stat_ff <= (rd_clr ? 4'h0 : irq_stat_ff) | irq_set;
    end
  end

  assign O_IRQ = |(irq_stat_ff & irq_mask_ff);

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  sequence s_loss_in_run;
    state_ff == fcls_pkg::ST_RUN && cont_loss && mode_ff != fcls_pkg::MODE_DISABLED;
  endsequence

  sequence s_txs_off;
    !O_BOOSTER_EN && !O_SVC_LASER_EN;
  endsequence

  property p_and_only;
    cont_loss |-> ovh_loss && pay_loss;
  endproperty
  a_and_only: assert property (p_and_only) else $error("loss without both inputs"); // RQ1

  property p_boost_off;
    s_loss_in_run |=> s_txs_off;
  endproperty
  a_boost_off: assert property (p_boost_off) else $error("transmitters not off"); // RQ2

  property p_alarm_demote;
    O_CONT_LOSS_ALARM |-> !O_OVERHEAD_ALARM && !O_PAYLOAD_ALARM;
  endproperty
  a_alarm_demote: assert property (p_alarm_demote) else $error("alarms not demoted"); // RQ3

  property p_preamp;
    $rose(pre_loss) |=> !O_PREAMP_EN;
  endproperty
  a_preamp: assert property (p_preamp) else $error("preamp stays on"); // RQ5

  property p_passive_block;
    passive_ff && state_ff == fcls_pkg::ST_SHUT |-> !O_SWITCH_PASS && !O_BOOSTER_EN;
  endproperty
  a_passive_block: assert property (p_passive_block) else $error("switch passes"); // RQ7

  property p_hold_off;
    state_ff == fcls_pkg::ST_SHUT && mode_ff == fcls_pkg::MODE_MANUAL &&
    !peer_pulse && !restart_req |=> state_ff == fcls_pkg::ST_SHUT;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("left shutdown unasked"); // RQ9

  property p_low_power;
    O_SVC_LOW_POWER || O_BOOSTER_REDUCED |-> state_ff == fcls_pkg::ST_SVC_PULSE ||
                                             state_ff == fcls_pkg::ST_AMP_PULSE;
  endproperty
  a_low_power: assert property (p_low_power) else $error("reduction misplaced"); // RQ12

  property p_svc_pulse_len;
    state_ff == fcls_pkg::ST_SVC_PULSE |-> sec_ff <= fcls_pkg::SVC_PULSE_S;
  endproperty
  a_svc_pulse_len: assert property (p_svc_pulse_len) else $error("svc pulse long"); // RQ13

  property p_amp_wait_len;
    state_ff == fcls_pkg::ST_AMP_WAIT |-> sec_ff <= fcls_pkg::AMP_WAIT_S;
  endproperty
  a_amp_wait_len: assert property (p_amp_wait_len) else $error("amp wait long"); // RQ14
endmodule

// file: test/fcls_peer.sv
/*
  peer node model across the fiber: sees our lasers, drives our overhead and payload loss pins and our pulse pin.
  assumes one clock shared with the controller; answer delay set by i_slow.
*/
`timescale 1ns/1ns
module fcls_peer #(
  parameter int P_TICK = 10
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_fiber_ok,
  input  wire logic i_slow,
  input  wire logic i_booster_en,
  input  wire logic i_svc_en,
  input  wire logic i_svc_low,
  output logic      o_ovh_loss,
  output logic      o_pay_loss,
  output logic      o_pulse
);
  logic run_ff;
  logic arm_ff;
  logic pulse_ff;
  logic seen_ff;
  logic [1:0] dark_ff;
  int   cnt_ff;
  logic seen_svc;
  logic seen_full;
  assign seen_svc  = i_fiber_ok & i_svc_en;
  assign seen_full = i_fiber_ok & (i_booster_en | (i_svc_en & ~i_svc_low));
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_ff   <= 1'b1;
      arm_ff   <= 1'b0;
      pulse_ff <= 1'b0;
      seen_ff  <= 1'b0;
      dark_ff  <= 2'h0;
      cnt_ff   <= 0;
    end else begin
      seen_ff <= seen_svc;
      // a one-cycle dark spell (our reset) must not look like a shutdown
      if (!seen_svc && !seen_full) begin
        if (dark_ff == 2'h2) run_ff <= 1'b0;
        else dark_ff <= dark_ff + 2'h1;
      end else begin
        dark_ff <= 2'h0;
        if (seen_full) run_ff <= 1'b1;
      end
      // slow answer lands after our 100 s wait, so a retry must come first
      if (arm_ff) begin
        if (cnt_ff >= (i_slow ? 105 * P_TICK : 5)) begin
          arm_ff   <= 1'b0;
          pulse_ff <= 1'b1;
          cnt_ff   <= 0;
        end else cnt_ff <= cnt_ff + 1;
      end else if (pulse_ff) begin
        if (cnt_ff >= 2 * P_TICK - 1) begin
          pulse_ff <= 1'b0;
          cnt_ff   <= 0;
        end else cnt_ff <= cnt_ff + 1;
      end else if (seen_ff && !seen_svc && !run_ff) begin
        arm_ff <= 1'b1;
        cnt_ff <= 0;
      end
    end
  end
  assign o_pulse    = i_fiber_ok & pulse_ff;
  assign o_ovh_loss = ~(i_fiber_ok & (run_ff | pulse_ff));
  assign o_pay_loss = ~(i_fiber_ok & run_ff);
endmodule

// file: test/fcls_top_tb.sv
/*
  self-checking bench for the shutdown controller with a peer model and an axi master.
  assumes the prescaler parameter shortened so one second is TK clock cycles.
*/
`timescale 1ns/1ns
module fcls_top_tb;
  localparam int TK = 10;
  logic        clk = 0, rst = 1, fiber = 1, slow = 0, ovr = 0;
  logic [3:0]  tv = 4'h0, aa = 4'h0, ra = 4'h0, ws = 4'hF;
  logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [31:0] wd = 0;
  logic        p_ovh, p_pay, p_pulse, awr, wr_r, bv, arr, rv;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  logic        ben, bred, pen, sen, slo, swp, cla, ova, paa, sli, irq;
  int          errors = 0, n_compared = 0, i, n;
  always #5 clk = ~clk;
  fcls_top #(.P_TICK_CYCLES(TK)) dut (.I_CLK(clk), .I_SYS_RST(rst),
    .I_OVERHEAD_LOSS(ovr ? tv[3] : p_ovh), .I_PAYLOAD_LOSS(ovr ? tv[2] : p_pay),
    .I_PRE_INPUT_LOSS(tv[1]), .I_SVC_FRAME_LOSS(tv[0]), .I_PEER_PULSE(p_pulse),
    .O_BOOSTER_EN(ben), .O_BOOSTER_REDUCED(bred), .O_PREAMP_EN(pen), .O_SVC_LASER_EN(sen),
    .O_SVC_LOW_POWER(slo), .O_SWITCH_PASS(swp), .O_CONT_LOSS_ALARM(cla),
    .O_OVERHEAD_ALARM(ova), .O_PAYLOAD_ALARM(paa), .O_SVC_LOSS_IND(sli), .O_IRQ(irq),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(aa), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_r), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_ARADDR(ra), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rdat),
    .S_AXI_RRESP(rr));
  fcls_peer #(.P_TICK(TK)) peer (.i_clk(clk), .i_rst(rst), .i_fiber_ok(fiber),
    .i_slow(slow), .i_booster_en(ben), .i_svc_en(sen), .i_svc_low(slo),
    .o_ovh_loss(p_ovh), .o_pay_loss(p_pay), .o_pulse(p_pulse));
  task automatic finish_test();
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tmo();
    errors++;
    finish_test();
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk32({31'h0, g}, {31'h0, e});
  endtask
  // alarm triple {cont, overhead, payload} for a loss pattern
  function automatic logic [2:0] exp_alarm(input logic o, input logic p);
    return {o & p, o & ~p, p & ~o};
  endfunction
  function automatic logic pin(input int k);
    case (k)
      0: return ben;
      1: return sen;
      2: return swp;
      default: return bred;
    endcase
  endfunction
  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask
  // the bound is the check: running out of it is counted as a mismatch
  task automatic wait_pin(input int k, input logic v, input int lim);
    int m;
    for (m = 0; m < lim && pin(k) !== v; m++) @(negedge clk);
    n_compared++;
    if (pin(k) !== v) tmo();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int m;
    logic [1:0] r;
    @(posedge clk);
    awv <= 1; wv <= 1; aa <= a; wd <= d; bry <= 1;
    for (m = 0; m < 40; m++) begin
      @(posedge clk);
      if (awv && awr) awv <= 0;
      if (wv && wr_r) wv <= 0;
      if (bv) begin
        r = br;
        bry <= 0;
        break;
      end
    end
    if (m == 40) tmo();
    chk32({30'h0, r}, {30'h0, fcls_pkg::RESP_OKAY});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    int m;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    arv <= 1; ra <= a; rry <= 1;
    for (m = 0; m < 40; m++) begin
      @(posedge clk);
      if (arv && arr) arv <= 0;
      if (rv) begin
        d = rdat;
        r = rr;
        rry <= 0;
        break;
      end
    end
    if (m == 40) tmo();
    chk32(d, e);
    chk32({30'h0, r}, {30'h0, er});
  endtask
  task automatic cut(input logic v);
    @(posedge clk);
    fiber <= v;
  endtask
  initial begin
    void'($urandom(65675));
    repeat (3) @(posedge clk);
    rst <= 0;
    cyc(2);
    chk32({ben, sen, swp, cla}, 4'hE);
    rd(fcls_pkg::OFS_CTRL, 32'h1, fcls_pkg::RESP_OKAY);
    rd(fcls_pkg::OFS_IRQ_MASK, 32'h0, fcls_pkg::RESP_OKAY);
    rd(4'h6, 32'h0, fcls_pkg::RESP_SLVERR);
    for (i = 0; i < 4; i++) begin
      wr(fcls_pkg::OFS_CTRL, i);
      rd(fcls_pkg::OFS_CTRL, i, fcls_pkg::RESP_OKAY);
    end
    wr(fcls_pkg::OFS_IRQ_MASK, 32'hA);
    // disabled mode: alarms follow the pins but only the preamp shuts
    wr(fcls_pkg::OFS_CTRL, 32'h0);
    @(posedge clk);
    ovr <= 1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      tv <= (i == 0) ? 4'hF : 4'($urandom);
      cyc(5);
      chk32({cla, ova, paa}, exp_alarm(tv[3], tv[2]));
      chk32({pen, sli, ben}, {~tv[1], tv[0], 1'b1});
    end
    @(posedge clk);
    tv <= 4'h0;
    ovr <= 0;
    cyc(5);
    chk1(irq, 0);
    rd(fcls_pkg::OFS_IRQ_STAT, 32'h1, fcls_pkg::RESP_OKAY);
    // auto mode cut, then a slow peer forces one retry
    wr(fcls_pkg::OFS_CTRL, 32'h1);
    cut(0);
    wait_pin(0, 0, 3 * TK + 4);
    chk1(sen, 0);
    cyc(5);
    chk32({sen, cla, ova, paa, irq}, 5'h19);
    rd(fcls_pkg::OFS_IRQ_STAT, 32'h3, fcls_pkg::RESP_OKAY);
    rd(fcls_pkg::OFS_IRQ_STAT, 32'h0, fcls_pkg::RESP_OKAY);
    cyc(50);
    chk1(ben, 0);
    slow <= 1;
    cut(1);
    wait_pin(1, 0, 3 * TK);
    wait_pin(1, 1, 110 * TK);
    chk1(slo, 1);
    for (n = 0; n < 3 * TK && sen; n++) @(negedge clk);
    chk1(n >= 2 * TK && n <= 2 * TK + 2, 1);
    wait_pin(0, 1, 250 * TK);
    chk1(bred, 1);
    wait_pin(3, 0, 12 * TK);
    cyc(5);
    chk32({ben, sen, slo, cla, irq}, 5'h19);
    rd(fcls_pkg::OFS_IRQ_STAT, 32'hC, fcls_pkg::RESP_OKAY);
    // manual mode waits for the restart bit
    slow <= 0;
    wr(fcls_pkg::OFS_CTRL, 32'h2);
    cut(0);
    wait_pin(0, 0, 3 * TK + 4);
    cut(1);
    cyc(300);
    chk32({ben, sen}, 2'h0);
    wr(fcls_pkg::OFS_CTRL, 32'h102);
    wait_pin(0, 1, 40 * TK);
    chk1(bred, 1);
    wait_pin(3, 0, 12 * TK);
    cyc(5);
    chk1(ben, 1);
    rd(fcls_pkg::OFS_CTRL, 32'h2, fcls_pkg::RESP_OKAY);
    // passive node: switch and service laser only
    wr(fcls_pkg::OFS_CTRL, 32'h5);
    cut(0);
    wait_pin(2, 0, 3 * TK + 4);
    chk32({ben, sen}, 2'h0);
    cut(1);
    wait_pin(2, 1, 150 * TK);
    cyc(2);
    chk32({ben, sen, slo}, 3'h2);
    // reset in mid-restart must land back in run
    wr(fcls_pkg::OFS_CTRL, 32'h1);
    cut(0);
    wait_pin(0, 0, 3 * TK + 4);
    cut(1);
    cyc(30);
    @(posedge clk);
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    cyc(2);
    chk32({ben, sen, swp}, 3'h7);
    rd(fcls_pkg::OFS_IRQ_STAT, 32'h0, fcls_pkg::RESP_OKAY);
    finish_test();
  end
endmodule
